/* File: rtl/dcp_device.sv */
// Purpose: dsp end of the control port: memories, safe update, core pacing
// Assumes: spi mode 0, link pins asynchronous to clk
// Notes:   one instruction slot per clk cycle
`timescale 1ns/1ps
module dcp_device #(
    parameter logic [6:0] CHIP_ADDR = 7'h00 // arbitrary value
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // link to host
    dcp_link_if.dev          link,
    // audio
    input  wire logic [23:0] audio_in,
    output logic [23:0]      audio_out,
    output logic             sample_tick,
    // core status
    output logic             boot_busy,
    output logic             core_stall,
    output logic [39:0]      core_instr,
    output logic [27:0]      core_param
);
    typedef enum {HDR_CHIP, HDR_AHI, HDR_ALO, HDR_DATA} dcp_hdr_t;

    // ----------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic       sclk_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1    <= 3'h7;
            sy2    <= 3'h7;
            sclk_q <= 1'b0;
        end else begin
            sy1    <= {link.spi_latch_select_n, link.mosi, link.sclk};
            sy2    <= sy1;
            sclk_q <= sy2[0];
        end
    end
    wire logic rise  = sy2[0] && !sclk_q;
    wire logic fall  = !sy2[0] && sclk_q;
    wire logic mosi  = sy2[1];
    wire logic idle  = sy2[2];

    // ----------------------------------------------------------
    // frame receiver
    // ----------------------------------------------------------
    dcp_hdr_t    hdr, next_hdr;
    logic [2:0]  bitc, next_bitc, dcnt, next_dcnt;
    logic [7:0]  sh, next_sh, b;
    logic        sel, next_sel, rd, next_rd, wr;
    logic [11:0] addr, next_addr;
    logic [39:0] acc, next_acc, tx, next_tx, rd_word;

    always_comb begin
        next_hdr = hdr; next_bitc = bitc; next_dcnt = dcnt; next_sh = sh;
        next_sel = sel; next_rd = rd; next_addr = addr; next_acc = acc;
        next_tx = tx; wr = 1'b0; b = {sh[6:0], mosi};
        if (idle) begin
            next_hdr = HDR_CHIP; next_bitc = '0; next_dcnt = '0;
        end else if (rise) begin
            next_sh   = b;
            next_bitc = bitc + 3'h1;
            if (bitc == 3'h7) begin
                case (hdr)
                    HDR_CHIP: begin
                        next_sel = b[7:1] == CHIP_ADDR;
                        next_rd  = b[0];
                        next_hdr = HDR_AHI;
                    end
                    HDR_AHI: begin
                        next_addr[11:8] = b[3:0];
                        next_hdr        = HDR_ALO;
                    end
                    HDR_ALO: begin
                        next_addr[7:0] = b;
                        next_hdr       = HDR_DATA;
                        next_dcnt      = '0;
                    end
                    default: begin
                        next_acc  = {acc[31:0], b};
                        next_dcnt = dcnt + 3'h1;
                        if (dcnt + 3'h1 == dcp_pkg::word_bytes(addr)) begin
                            wr        = sel && !rd;
                            next_addr = addr + 12'h1;
                            next_dcnt = '0;
                        end
                    end
                endcase
            end
        end else if (fall && hdr == HDR_DATA) begin
            next_tx = (bitc == 3'h0 && dcnt == 3'h0) ? rd_word : {tx[38:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hdr <= HDR_CHIP; bitc <= '0; dcnt <= '0; sh <= '0; sel <= 1'b0;
            rd <= 1'b0; addr <= '0; acc <= '0; tx <= '0;
        end else begin
            hdr <= next_hdr; bitc <= next_bitc; dcnt <= next_dcnt; sh <= next_sh;
            sel <= next_sel; rd <= next_rd; addr <= next_addr; acc <= next_acc; tx <= next_tx;
        end
    end

    // miso driven only while selected for a read
    assign link.miso_out  = tx[39];
    assign link.miso_oe_n = !(sel && rd && !idle && hdr == HDR_DATA);

    // ----------------------------------------------------------
    // memories and control state
    // ----------------------------------------------------------
    logic [27:0] param_mem [dcp_pkg::MEM_DEPTH];
    logic [39:0] prog_mem  [dcp_pkg::MEM_DEPTH];
    logic [27:0] safe_data [dcp_pkg::SAFE_SLOTS];
    logic [9:0]  safe_addr [dcp_pkg::SAFE_SLOTS];
    logic [4:0]  pending, next_pending;
    logic [15:0] ctrl, next_ctrl;
    logic [10:0] boot_cnt, next_boot_cnt;
    logic [9:0]  slot, next_slot, slots_per;
    logic        pm_we, pg_we, port_pm, safe_go;
    logic [9:0]  pm_a, pg_a;
    logic [27:0] pm_d;
    logic [39:0] pg_d, rd_raw;
    logic [2:0]  si;
    logic [11:0] soff, aoff;

    assign boot_busy = !boot_cnt[10];
    assign soff = addr - dcp_pkg::SAFE_DATA_BASE;
    assign aoff = addr - dcp_pkg::SAFE_ADDR_BASE;
    assign si   = slot[2:0];
    assign port_pm = wr && addr < dcp_pkg::PROG_BASE && !boot_busy;
    // safe commit only in reserved slots of each sample
    assign safe_go = slot < 10'(dcp_pkg::SAFE_SLOTS) && pending[si] && !port_pm && !boot_busy;

    // write arbitration: boot, then port, then safe update
    always_comb begin
        pm_we = 1'b1; pm_a = boot_cnt[9:0]; pm_d = '0;
        pg_we = 1'b1; pg_a = boot_cnt[9:0]; pg_d = dcp_pkg::BOOT_INSTR;
        if (!boot_busy) begin
            pm_we = port_pm || safe_go;
            pm_a  = port_pm ? addr[9:0] : safe_addr[si];
            pm_d  = port_pm ? next_acc[27:0] : safe_data[si];
            pg_we = wr && addr >= dcp_pkg::PROG_BASE && addr < dcp_pkg::REG_BASE;
            pg_a  = addr[9:0];
            pg_d  = next_acc; // word including the byte just shifted in
        end
    end

    // control register, pending slots, boot walk
    always_comb begin
        next_ctrl     = ctrl;
        next_boot_cnt = boot_busy ? boot_cnt + 11'h1 : boot_cnt;
        next_pending  = pending;
        if (safe_go) next_pending[si] = 1'b0;
        if (wr && addr == dcp_pkg::CORE_CTRL_ADDR) next_ctrl = next_acc[15:0];
        // set wins over commit clear
        if (wr && addr >= dcp_pkg::SAFE_DATA_BASE && addr < dcp_pkg::SAFE_ADDR_BASE)
            next_pending[soff[2:0]] = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0; boot_cnt <= '0; pending <= '0;
        end else begin
            ctrl <= next_ctrl; boot_cnt <= next_boot_cnt; pending <= next_pending;
        end
    end

    // memory and safe slot writes
    always_ff @(posedge clk) begin
        if (pm_we) param_mem[pm_a] <= pm_d;
        if (pg_we) prog_mem[pg_a] <= pg_d;
        if (wr && addr >= dcp_pkg::SAFE_DATA_BASE && addr < dcp_pkg::SAFE_ADDR_BASE)
            safe_data[soff[2:0]] <= next_acc[27:0];
        if (wr && addr >= dcp_pkg::SAFE_ADDR_BASE && aoff < 12'(dcp_pkg::SAFE_SLOTS))
            safe_addr[aoff[2:0]] <= next_acc[9:0];
    end

    // read mux; data memory has no window here
    always_comb begin
        rd_raw = '0;
        if (addr < dcp_pkg::PROG_BASE) rd_raw = {12'h0, param_mem[addr[9:0]]};
        else if (addr < dcp_pkg::REG_BASE) rd_raw = prog_mem[addr[9:0]];
        else if (addr == dcp_pkg::CORE_CTRL_ADDR) rd_raw = {24'h0, ctrl};
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rd_word <= '0;
        else rd_word <= rd_raw << (8 * (dcp_pkg::PROG_BYTES - dcp_pkg::word_bytes(addr)));
    end

    // ----------------------------------------------------------
    // core pacing and audio path
    // ----------------------------------------------------------
    function automatic logic [23:0] clip(input logic [27:0] x);
        if (x[27:23] == {5{x[27]}}) return x[23:0];
        return x[27] ? dcp_pkg::OUT_MIN : dcp_pkg::OUT_MAX;
    endfunction : clip

    logic [27:0] core_word, next_core_word;
    logic [23:0] next_out;
    logic        last;

    always_comb begin
        slots_per = 10'h3ff;
        case (ctrl[dcp_pkg::CTRL_RATE_LSB +: 2])
            dcp_pkg::RATE_DOUBLE: slots_per = 10'h1ff;
            dcp_pkg::RATE_QUAD:   slots_per = 10'h0ff;
            default:              slots_per = 10'h3ff;
        endcase
        last           = slot >= slots_per;
        next_slot      = last ? 10'h0 : slot + 10'h1;
        next_core_word = core_word;
        next_out       = audio_out;
        if (last) begin
            // default program: input straight through
            next_core_word = {{(dcp_pkg::CORE_W - dcp_pkg::IN_W){audio_in[23]}}, audio_in};
            next_out = ctrl[dcp_pkg::CTRL_UNMUTE] ? clip(core_word) : '0;
        end
        if (!ctrl[dcp_pkg::CTRL_CLR_BIT]) next_core_word = '0;
        // core loses coefficient access during port writes to coefficient memory
        core_stall = port_pm && slot >= 10'(dcp_pkg::SAFE_SLOTS);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot <= '0; core_word <= '0; audio_out <= '0; sample_tick <= 1'b0;
            core_instr <= '0; core_param <= '0;
        end else begin
            slot        <= next_slot;
            core_word   <= next_core_word;
            audio_out   <= next_out;
            sample_tick <= last;
            core_instr  <= prog_mem[slot];
            if (slot >= 10'(dcp_pkg::SAFE_SLOTS) && !port_pm) core_param <= param_mem[slot];
        end
    end
endmodule : dcp_device

/* File: rtl/dcp_fifo.sv */
// Purpose: synchronous word fifo with valid/ready on both sides
// Assumes: single clock
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module dcp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    logic [AW:0]  next_wp;
    logic [AW:0]  next_rp;

    // full and empty from pointer compare
    assign in_ready  = (wp - rp) != (AW+1)'(DEPTH);
    assign out_valid = wp != rp;
    assign out_data  = mem[rp[AW-1:0]];

    always_comb begin
        next_wp = wp + (AW+1)'(in_valid && in_ready);
        next_rp = rp + (AW+1)'(out_valid && out_ready);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    // storage write
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule : dcp_fifo

/* File: rtl/dcp_host.sv */
// Purpose: host end of the control port: frames words onto the spi link
// Assumes: commands queue in a 16-word fifo
// Notes:   sclk made here by a divider; idles low
`timescale 1ns/1ps
module dcp_host #(
    parameter logic [6:0] CHIP_ADDR = 7'h00, // arbitrary value
    parameter int         DEPTH     = 16
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // link to device
    dcp_link_if.host         link,
    // command queue
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic        cmd_last,
    input  wire logic [11:0] cmd_addr,
    input  wire logic [39:0] cmd_data,
    // read answers and busy
    output logic             rsp_valid,
    output logic [39:0]      rsp_data,
    output logic             busy
);
    typedef enum {H_IDLE, H_SHIFT, H_NEXT, H_END} dcp_host_st_t;
    localparam int FW = 54;

    logic          f_valid, f_ready;
    logic [FW-1:0] f_data;
    dcp_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .in_valid (cmd_valid),
        .in_ready (cmd_ready),
        .in_data  ({cmd_read, cmd_last, cmd_addr, cmd_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data (f_data)
    );
    wire logic        f_rd   = f_data[53];
    wire logic        f_last = f_data[52];
    wire logic [11:0] f_addr = f_data[51:40];
    wire logic [39:0] f_word = f_data[39:0];

    // ----------------------------------------------------------
    // miso synchroniser and clock divider
    // ----------------------------------------------------------
    logic ms1, ms2;
    logic [7:0] div;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms1 <= 1'b1; ms2 <= 1'b1; div <= '0;
        end else begin
            ms1 <= link.miso; ms2 <= ms1;
            div <= (div == 8'(dcp_pkg::SCLK_HALF - 1)) ? 8'h0 : div + 8'h1;
        end
    end
    wire logic tick = div == 8'(dcp_pkg::SCLK_HALF - 1);

    // ----------------------------------------------------------
    // framer
    // ----------------------------------------------------------
    dcp_host_st_t st, next_st;
    logic [63:0]  sh, next_sh;
    logic [6:0]   nbits, next_nbits;
    logic [39:0]  rx, next_rx, next_rsp_data;
    logic [11:0]  cur, next_cur;
    logic         sclk, next_sclk, lat_n, next_lat_n, rdm, next_rdm;
    logic         lastm, next_lastm, next_rsp_valid;
    logic [2:0]   nb;

    always_comb begin
        next_st = st; next_sh = sh; next_nbits = nbits; next_rx = rx; next_cur = cur;
        next_sclk = sclk; next_lat_n = lat_n; next_rdm = rdm; next_lastm = lastm;
        next_rsp_valid = 1'b0; next_rsp_data = rsp_data; f_ready = 1'b0;
        nb = dcp_pkg::word_bytes(st == H_NEXT ? cur + 12'h1 : (st == H_IDLE ? f_addr : cur));
        case (st)
            H_IDLE: if (f_valid && tick) begin
                f_ready    = 1'b1;
                next_sh    = {CHIP_ADDR, f_rd, 4'h0, f_addr, f_word << (8 * (dcp_pkg::PROG_BYTES - nb))};
                next_nbits = 7'(dcp_pkg::HDR_BITS) + {1'b0, nb, 3'h0};
                next_lat_n = 1'b0;
                next_cur   = f_addr;
                next_rdm   = f_rd;
                next_lastm = f_last;
                next_st    = H_SHIFT;
            end
            H_SHIFT: if (tick) begin
                next_sclk = !sclk;
                if (!sclk) begin
                    next_rx = {rx[38:0], ms2};
                end else begin
                    next_sh    = {sh[62:0], 1'b0};
                    next_nbits = nbits - 7'h1;
                    if (nbits == 7'h1) begin
                        next_rsp_valid = rdm;
                        next_rsp_data  = rx & ({40{1'b1}} >> (8 * (dcp_pkg::PROG_BYTES - nb)));
                        next_st        = lastm ? H_END : H_NEXT;
                    end
                end
            end
            H_NEXT: if (f_valid) begin // burst word, address implied
                f_ready    = 1'b1;
                next_cur   = cur + 12'h1;
                next_sh    = {f_word << (8 * (dcp_pkg::PROG_BYTES - nb)), 24'h0};
                next_nbits = {1'b0, nb, 3'h0};
                next_lastm = f_last;
                next_st    = H_SHIFT;
            end
            H_END: if (tick) begin
                next_lat_n = 1'b1;
                next_st    = H_IDLE;
            end
            default: next_st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= H_IDLE; sh <= '0; nbits <= '0; rx <= '0; cur <= '0; sclk <= 1'b0;
            lat_n <= 1'b1; rdm <= 1'b0; lastm <= 1'b0; rsp_valid <= 1'b0; rsp_data <= '0;
        end else begin
            st <= next_st; sh <= next_sh; nbits <= next_nbits; rx <= next_rx; cur <= next_cur;
            sclk <= next_sclk; lat_n <= next_lat_n; rdm <= next_rdm; lastm <= next_lastm;
            rsp_valid <= next_rsp_valid; rsp_data <= next_rsp_data;
        end
    end

    assign link.sclk               = sclk;
    assign link.mosi               = sh[63];
    assign link.spi_latch_select_n = lat_n;
    assign busy                    = st != H_IDLE || f_valid;
endmodule : dcp_host

/* File: rtl/dcp_link_if.sv */
// Purpose: 4-wire spi control link between host and device
// Assumes: miso is pulled high when nobody drives it
// Notes:   miso wire resolved here from the enable
`timescale 1ns/1ps
interface dcp_link_if;
    logic sclk;
    logic mosi;
    logic spi_latch_select_n;
    logic miso_out;
    logic miso_oe_n;
    logic miso;

    // wire level of the shared data-out line
    assign miso = miso_oe_n ? 1'b1 : miso_out;

    modport dev  (input sclk, input mosi, input spi_latch_select_n, output miso_out, output miso_oe_n);
    modport host (output sclk, output mosi, output spi_latch_select_n, input miso);
endinterface : dcp_link_if

/* File: rtl/dcp_pkg.sv */
// Purpose: shared constants for the dsp control port link ends
// Assumes: 4-wire spi framing, 12-bit target address
// Notes:   byte counts per word depend on the address only
package dcp_pkg;
    // ----------------------------------------------------------
    // address map
    // ----------------------------------------------------------
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] PROG_BASE      = 12'h400;
    localparam logic [11:0] REG_BASE       = 12'h800;
    localparam logic [11:0] SAFE_DATA_BASE = 12'h810;
    localparam logic [11:0] SAFE_ADDR_BASE = 12'h815;
    localparam logic [11:0] CORE_CTRL_ADDR = 12'h81c;
    localparam int          SAFE_SLOTS     = 5;
    localparam int          MEM_DEPTH      = 1024;
    // ----------------------------------------------------------
    // word widths and numeric format
    // ----------------------------------------------------------
    localparam int          IN_W    = 24;
    localparam int          CORE_W  = 28;
    localparam int          PROG_W  = 40;
    localparam int          HDR_BITS = 24;
    localparam logic [31:0] UNITY   = 32'h0080_0000; // 1.0 in 5.23
    localparam logic [23:0] OUT_MAX = 24'h7f_ffff;
    localparam logic [23:0] OUT_MIN = 24'h80_0000;
    // ----------------------------------------------------------
    // bytes per word
    // ----------------------------------------------------------
    localparam logic [2:0] PARAM_BYTES     = 3'h4;
    localparam logic [2:0] PROG_BYTES      = 3'h5;
    localparam logic [2:0] REG_BYTES       = 3'h4;
    localparam logic [2:0] SAFE_DATA_BYTES = 3'h5;
    localparam logic [2:0] SAFE_ADDR_BYTES = 3'h2;
    localparam logic [2:0] CTRL_BYTES      = 3'h2;
    // ----------------------------------------------------------
    // core control fields, rates, timing
    // ----------------------------------------------------------
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_CLR_BIT  = 2;
    localparam int CTRL_UNMUTE   = 3;
    localparam logic [1:0] RATE_DOUBLE = 2'h1;
    localparam logic [1:0] RATE_QUAD   = 2'h2;
    localparam logic [39:0] BOOT_INSTR = 40'h00_0000_0000;
    localparam int CLK_NS    = 8;
    localparam int SCLK_NS   = 160;
    localparam int SCLK_HALF = SCLK_NS / (2 * CLK_NS);

    // data bytes expected for one word at address a
    function automatic logic [2:0] word_bytes(input logic [11:0] a);
        if (a < PROG_BASE) return PARAM_BYTES;
        if (a < REG_BASE) return PROG_BYTES;
        if (a >= SAFE_DATA_BASE && a < SAFE_ADDR_BASE) return SAFE_DATA_BYTES;
        if (a >= SAFE_ADDR_BASE && a < SAFE_ADDR_BASE + 12'(SAFE_SLOTS)) return SAFE_ADDR_BYTES;
        if (a == CORE_CTRL_ADDR) return CTRL_BYTES;
        return REG_BYTES;
    endfunction : word_bytes
endpackage : dcp_pkg

/* File: verification/dcp_link_assertions.sv */
// Purpose: wire checks on the control link
// Assumes: spi mode 0, ten clk per half bit
// Notes:   sees the interface wires only
`timescale 1ns/1ps
module dcp_link_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link wires
    input wire logic sclk,
    input wire logic mosi,
    input wire logic spi_latch_select_n,
    input wire logic miso_out,
    input wire logic miso_oe_n
);
    logic       sclk_q;
    logic [7:0] n_rise;
    logic [7:0] next_n_rise;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rise; $rose(sclk) && !spi_latch_select_n; endsequence
    sequence s_gap; spi_latch_select_n[*8]; endsequence
    // count clock rises in a frame
    always_comb begin
        next_n_rise = spi_latch_select_n ? 8'h00 : n_rise + {7'h00, sclk && !sclk_q};
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            n_rise <= 8'h00;
        end else begin
            sclk_q <= sclk;
            n_rise <= next_n_rise;
        end
    end
    idle_low_a: assert property (spi_latch_select_n |-> !sclk) else $error("clock out of frame");
    half_high_a: assert property (s_rise |-> sclk[*8]) else $error("short high");
    mosi_hold_a: assert property (s_rise |=> $stable(mosi)[*7]) else $error("mosi moved");
    first_bit_a: assert property ($fell(spi_latch_select_n) |-> ##[1:24] $rose(sclk)) else $error("no clock");
    frame_gap_a: assert property ($rose(spi_latch_select_n) |-> s_gap) else $error("short gap");
    whole_bytes_a: assert property ($rose(spi_latch_select_n) |-> n_rise[2:0] == 3'h0 && n_rise >= 8'h28)
        else $error("partial byte");
    miso_off_a: assert property (s_gap |-> miso_oe_n) else $error("miso driven");
    miso_hold_a: assert property ((s_rise and !miso_oe_n) |=> $stable(miso_out)[*7]) else $error("miso moved");
endmodule : dcp_link_assertions

/* File: verification/test_dsp_control_port_memory_access.sv */
// Purpose: host and device joined over the link
// Assumes: both ends use chip address 0
// Notes:   writes are read back over the link
`timescale 1ns/1ps
module test_dsp_control_port_memory_access;
    logic        clk, rst_n, cmd_valid, cmd_read, cmd_last, cmd_ready, rsp_valid, busy, boot_busy, sample_tick;
    logic [11:0] cmd_addr;
    logic [39:0] cmd_data, rsp_data;
    logic [23:0] audio_in, audio_out, hdr;
    logic [7:0]  nbit;
    int          miscompares, n_checks, cycles;
    dcp_link_if u_dcp_link_if ();
    dcp_device u_dcp_device (.clk, .rst_n, .link(u_dcp_link_if), .audio_in, .audio_out, .sample_tick,
        .boot_busy, .core_stall(), .core_instr(), .core_param());
    dcp_host u_dcp_host (.clk, .rst_n, .link(u_dcp_link_if), .cmd_valid, .cmd_ready, .cmd_read, .cmd_last,
        .cmd_addr, .cmd_data, .rsp_valid, .rsp_data, .busy);
    dcp_link_assertions u_dcp_link_assertions (.clk, .rst_n, .sclk(u_dcp_link_if.sclk), .mosi(u_dcp_link_if.mosi),
        .spi_latch_select_n(u_dcp_link_if.spi_latch_select_n), .miso_out(u_dcp_link_if.miso_out),
        .miso_oe_n(u_dcp_link_if.miso_oe_n));
    // header bits as they cross the wire
    always @(posedge u_dcp_link_if.sclk) begin
        if (nbit < 8'd24) hdr <= {hdr[22:0], u_dcp_link_if.mosi};
        nbit <= nbit + 8'h01;
    end
    always @(posedge u_dcp_link_if.spi_latch_select_n) nbit <= 8'h00;
    // clock and hang limit
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic push(input logic rd, input logic last, input logic [11:0] a, input logic [39:0] d);
        @(posedge clk);
        #1 {cmd_valid, cmd_read, cmd_last, cmd_addr, cmd_data} = {1'b1, rd, last, a, d};
        @(posedge clk);
        for (int i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(posedge clk);
        #1 cmd_valid = 1'b0;
    endtask : push
    task automatic idle();
        for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask : idle
    task automatic rd_chk(input logic [11:0] a, input logic [39:0] exp);
        push(1'b1, 1'b1, a, 40'h0);
        for (int i = 0; i < 3000 && rsp_valid !== 1'b1; i++) @(posedge clk);
        check({39'h0, rsp_valid}, 40'h1);
        check(rsp_data, exp);
        idle();
    endtask : rd_chk
    // reset contents: zero coefficients, boot word
    task automatic t_boot();
        audio_in = 24'h80_0001;
        for (int i = 0; i < 2000 && boot_busy !== 1'b0; i++) @(posedge clk);
        check({16'h0, audio_out}, 40'h0);
        tick_gap(40'h400);
        rd_chk(12'h005, 40'h0);
        rd_chk(12'h7ff, dcp_pkg::BOOT_INSTR);
    endtask : t_boot
    // one word per memory, top pad bits dropped
    task automatic t_single();
        push(1'b0, 1'b1, 12'h003, 40'h00_f080_0000);
        idle();
        check({16'h0, hdr}, {16'h0, 7'h00, 1'b0, 4'h0, 12'h003});
        rd_chk(12'h003, {8'h00, dcp_pkg::UNITY});
        push(1'b0, 1'b1, 12'h4a5, 40'hde_adbe_ef01);
        idle();
        check({16'h0, hdr}, {16'h0, 7'h00, 1'b0, 4'h0, 12'h4a5});
        rd_chk(12'h4a5, 40'hde_adbe_ef01);
    endtask : t_single
    // burst across the coefficient to instruction boundary
    task automatic t_burst();
        push(1'b0, 1'b0, 12'h3ff, 40'h00_0123_4567);
        push(1'b0, 1'b1, 12'h000, 40'h12_3456_789a);
        idle();
        rd_chk(12'h3ff, 40'h00_0123_4567);
        rd_chk(12'h400, 40'h12_3456_789a);
        push(1'b0, 1'b1, 12'h900, 40'h00_5555_aaaa);
        idle();
        rd_chk(12'h900, 40'h0);
    endtask : t_burst
    // cycles from one sample tick to the next
    task automatic tick_gap(input logic [39:0] exp);
        int n;
        @(negedge clk);
        for (int i = 0; i < 1100 && sample_tick !== 1'b1; i++) @(negedge clk);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < 1100 && sample_tick !== 1'b1);
        check(40'(n), exp);
    endtask : tick_gap
    // quad rate, unmuted pass-through, then a safe coefficient update
    task automatic t_audio();
        push(1'b0, 1'b1, 12'h81c, 40'h0e);
        idle();
        rd_chk(12'h81c, 40'h0e);
        tick_gap(40'h100);
        check({16'h0, audio_out}, {16'h0, 24'h80_0001});
        push(1'b0, 1'b1, 12'h815, 40'h10);
        push(1'b0, 1'b1, 12'h810, 40'h00_0234_5678);
        idle();
        rd_chk(12'h010, 40'h00_0234_5678);
    endtask : t_audio
    task automatic summarize();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    // reset, then the scenarios in turn
    initial begin
        {rst_n, cmd_valid, cmd_read, cmd_last, cmd_addr, cmd_data, audio_in, hdr, nbit} = '0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        t_boot();
        t_single();
        t_burst();
        t_audio();
        summarize();
    end
endmodule : test_dsp_control_port_memory_access
